/* meter_params.svh */
`ifndef METER_PARAMS_SVH
`define METER_PARAMS_SVH

// =============================================================
// Clock and timing
`define CLK_HZ          50000000
`define DEBOUNCE_MS     10
`define DEBOUNCE_CYC    ((`CLK_HZ / 1000) * `DEBOUNCE_MS)
`define SCROLL_MS       250
`define SCROLL_CYC      ((`CLK_HZ / 1000) * `SCROLL_MS)
`define DROPOUT_MS      40
`define DROPOUT_CYC     ((`CLK_HZ / 1000) * `DROPOUT_MS)
`define SECOND_S        1
`define SECOND_CYC      (`CLK_HZ * `SECOND_S)

// =============================================================
// Mode dwell times in seconds
`define RESET_SHOW_S    3'h2
`define OFFER_S         3'h3
`define HIBER_SHOW_S    3'h1

// =============================================================
// Register offsets
`define REG_STATUS      8'h00
`define REG_TIME        8'h04
`define REG_FREQ        8'h08
`define REG_PWM_REF     8'h0C
`define REG_VERSION     8'h10

// =============================================================
// Field positions and reset values
`define STATUS_MODE_LSB  0
`define STATUS_TRIAC_BIT 4
`define STATUS_EDIT_LSB  8
`define PWM_REF_RESET    10'h200

// Version digits, values arbitrary
`define VER_D8          4'h1
`define VER_D6          4'h0
`define VER_D5          4'h3

// =============================================================
// Bus responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

/* meter_pkg.sv */
package meter_pkg;

    typedef enum logic [2:0] {
        ST_RESET      = 3'h0,
        ST_ENTRY      = 3'h1,
        ST_MEASURE    = 3'h2,
        ST_OFFER      = 3'h3,
        ST_SLEEP      = 3'h4,
        ST_HIBER_SHOW = 3'h5,
        ST_HIBERNATE  = 3'h6
    } mode_t;

    // Digit characters are {1'b1, bcd}
    typedef enum logic [4:0] {
        CH_BLANK = 5'h00,
        CH_S     = 5'h01,
        CH_H     = 5'h02
    } char_t;

    typedef logic [5:0][3:0] time_t;

endpackage

/* button_debounce.sv */
`timescale 1ns/10ps

module button_debounce #(
    parameter int          N   = 4,
    parameter logic [31:0] CYC = 32'h0007A120
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Raw buttons, high when pressed
    input  wire logic [N-1:0] raw,
    // Filtered level and edge pulses
    output logic      [N-1:0] held,
    output logic      [N-1:0] press,
    output logic      [N-1:0] release_p
);

    typedef struct packed {
        logic [N-1:0]       stable;
        logic [N-1:0]       press;
        logic [N-1:0]       release_p;
        logic [N-1:0][31:0] cnt;
    } deb_state_t;

    deb_state_t s;
    deb_state_t n;

    // =========================================================
    // Per-button filter
    always_comb begin
        n = s;
        n.press = '0;
        n.release_p = '0;
        for (int i = 0; i < N; i++) begin
            if (raw[i] == s.stable[i]) begin
                n.cnt[i] = '0;
            end else if (s.cnt[i] == CYC - 32'h1) begin
                n.cnt[i] = '0;
                n.stable[i] = raw[i];
                n.press[i] = raw[i];
                n.release_p[i] = !raw[i];
            end else begin
                n.cnt[i] = s.cnt[i] + 32'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign held = s.stable;
    assign press = s.press;
    assign release_p = s.release_p;

endmodule

/* meter_mode_time_entry.sv */
`timescale 1ns/10ps
`include "meter_params.svh"

module meter_mode_time_entry
    import meter_pkg::*;
#(
    parameter logic [31:0] DEBOUNCE_CYC = `DEBOUNCE_CYC,
    parameter logic [31:0] SCROLL_CYC   = `SCROLL_CYC,
    parameter logic [31:0] DROPOUT_CYC  = `DROPOUT_CYC,
    parameter logic [31:0] SECOND_CYC   = `SECOND_CYC
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Pushbuttons, high when pressed
    input  wire logic             load_switch_button,
    input  wire logic             increment_button,
    input  wire logic             enter_button,
    input  wire logic             decrement_button,
    // Comparator and serial sense lines
    input  wire logic             voltage_sense_line,
    input  wire logic             current_sense_line,
    input  wire logic             serial_rx_line,
    // Front end outputs
    output logic                  combined_wake_interrupt,
    output logic                  load_triac_gate,
    output logic                  pwm_reference,
    output logic                  meas_start,
    output logic                  cpu_clock_run,
    output logic                  periph_power_on,
    output logic [7:0][4:0]       display_char,
    output logic                  display_colon,
    // AXI4-Lite write
    input  wire logic [7:0]       awaddr,
    input  wire logic             awvalid,
    output logic                  awready,
    input  wire logic [31:0]      wdata,
    input  wire logic [3:0]       wstrb,
    input  wire logic             wvalid,
    output logic                  wready,
    output logic [1:0]            bresp,
    output logic                  bvalid,
    input  wire logic             bready,
    // AXI4-Lite read
    input  wire logic [7:0]       araddr,
    input  wire logic             arvalid,
    output logic                  arready,
    output logic [31:0]           rdata,
    output logic [1:0]            rresp,
    output logic                  rvalid,
    input  wire logic             rready
);

    typedef struct packed {
        mode_t          mode;
        logic [1:0]     edit;
        time_t          tdig;
        logic           triac_on;
        logic [31:0]    tick_cnt;
        logic [2:0]     sec_cnt;
        logic [31:0]    drop_cnt;
        logic [31:0]    scroll_cnt;
        logic           v_prev;
        logic           c_prev;
        logic           rx_prev;
        logic [7:0]     freq_acc;
        logic [7:0]     freq;
        logic [9:0]     pwm_ref;
        logic [9:0]     pwm_cnt;
        logic           pwm_out;
        logic           wake;
        logic           gate;
        logic           meas_start;
        logic           clk_run;
        logic           periph_on;
        logic [7:0][4:0] disp;
        logic           colon;
        logic           aw_got;
        logic [7:0]     aw_addr;
        logic           w_got;
        logic [31:0]    wdata;
        logic [3:0]     wstrb;
        logic           awready;
        logic           wready;
        logic           bvalid;
        logic [1:0]     bresp;
        logic           arready;
        logic           rvalid;
        logic [31:0]    rdata;
        logic [1:0]     rresp;
    } state_t;

    state_t      s;
    state_t      n;
    logic [3:0]  btn_held;
    logic [3:0]  btn_press;
    logic [3:0]  btn_rel;
    logic        v_edge;
    logic        c_edge;
    logic        rx_edge;
    logic        tick;
    logic        dropout;
    logic        rep;

    // =========================================================
    // Helpers
    function automatic logic [4:0] char_of(input logic [3:0] d);
        return {1'b1, d};
    endfunction

    function automatic logic [3:0] digit_max(input time_t t, input logic [1:0] e);
        logic top;
        top = (t[5] == 4'h2) && (t[4] == 4'h4);
        unique case (e)
            2'h0: return 4'h2;
            2'h1: return (t[5] == 4'h2) ? 4'h4 : 4'h9;
            2'h2: return top ? 4'h0 : 4'h5;
            2'h3: return top ? 4'h0 : 4'h9;
        endcase
    endfunction

    function automatic time_t time_next(input time_t t);
        time_t r;
        r = t;
        r[0] = t[0] + 4'h1;
        if (r[0] == 4'hA) begin
            r[0] = 4'h0;
            r[1] = t[1] + 4'h1;
        end
        if (r[1] == 4'h6) begin
            r[1] = 4'h0;
            r[2] = t[2] + 4'h1;
        end
        if (r[2] == 4'hA) begin
            r[2] = 4'h0;
            r[3] = t[3] + 4'h1;
        end
        if (r[3] == 4'h6) begin
            r[3] = 4'h0;
            r[4] = t[4] + 4'h1;
        end
        if (r[4] == 4'hA) begin
            r[4] = 4'h0;
            r[5] = t[5] + 4'h1;
        end
        if ((r[5] == 4'h2) && (r[4] == 4'h4)) begin
            r = '0;
        end
        return r;
    endfunction

    // =========================================================
    // Button filtering
    button_debounce #(
        .N   (4),
        .CYC (DEBOUNCE_CYC)
    ) u_debounce (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .raw       ({decrement_button, enter_button, increment_button, load_switch_button}),
        .held      (btn_held),
        .press     (btn_press),
        .release_p (btn_rel)
    );

    assign v_edge  = voltage_sense_line ^ s.v_prev;
    assign c_edge  = current_sense_line ^ s.c_prev;
    assign rx_edge = serial_rx_line ^ s.rx_prev;
    assign tick    = s.tick_cnt == SECOND_CYC - 32'h1;
    assign dropout = s.drop_cnt >= DROPOUT_CYC - 32'h1;
    assign rep     = s.scroll_cnt == SCROLL_CYC - 32'h1;

    // =========================================================
    // Next state
    always_comb begin
        logic [2:0] pos;
        logic [3:0] mx;
        logic [3:0] cur;
        logic       up;
        logic       dn;
        pos = 3'h5 - {1'b0, s.edit};
        mx  = digit_max(s.tdig, s.edit);
        cur = s.tdig[pos];
        up  = 1'b0;
        dn  = 1'b0;
        n = s;
        n.v_prev = voltage_sense_line;
        n.c_prev = current_sense_line;
        n.rx_prev = serial_rx_line;
        n.wake = v_edge | c_edge | rx_edge;
        n.pwm_cnt = s.pwm_cnt + 10'h001;
        n.pwm_out = s.pwm_cnt < s.pwm_ref;
        n.tick_cnt = tick ? 32'h0 : s.tick_cnt + 32'h1;
        n.meas_start = 1'b0;
        if (tick) begin
            n.freq = s.freq_acc;
            n.freq_acc = 8'h00;
            n.sec_cnt = (s.sec_cnt == 3'h7) ? s.sec_cnt : s.sec_cnt + 3'h1;
        end else if (voltage_sense_line && !s.v_prev) begin
            n.freq_acc = s.freq_acc + 8'h01;
        end
        n.drop_cnt = v_edge ? 32'h0 : (dropout ? s.drop_cnt : s.drop_cnt + 32'h1);

        // Load switch and gate pulses at each voltage zero crossing while the triac is on
        if (btn_rel[0] && (s.mode != ST_RESET)) begin
            n.triac_on = !s.triac_on;
        end
        n.gate = s.triac_on && v_edge;

        // Held scroll repeat
        if ((btn_held[1] || btn_held[3]) && !rep && !btn_press[1] && !btn_press[3]) begin
            n.scroll_cnt = s.scroll_cnt + 32'h1;
        end else begin
            n.scroll_cnt = 32'h0;
        end
        up = btn_press[1] || (btn_held[1] && rep);
        dn = !up && (btn_press[3] || (btn_held[3] && rep));

        unique case (s.mode)
            ST_RESET: begin
                if (tick && (s.sec_cnt == `RESET_SHOW_S - 3'h1)) begin
                    n.mode = ST_ENTRY;
                    n.edit = 2'h0;
                    n.tdig = '0;
                end
            end
            ST_ENTRY: begin
                if (btn_press[2]) begin
                    if (s.edit == 2'h3) begin
                        n.mode = ST_MEASURE;
                    end else begin
                        n.edit = s.edit + 2'h1;
                        n.tdig[pos - 3'h1] = 4'h0;
                    end
                end else if (up) begin
                    n.tdig[pos] = (cur >= mx) ? 4'h0 : cur + 4'h1;
                end else if (dn) begin
                    n.tdig[pos] = (cur == 4'h0 || cur > mx) ? mx : cur - 4'h1;
                end
            end
            ST_MEASURE: begin
                if (dropout) begin
                    n.mode = ST_OFFER;
                end else if (tick) begin
                    n.tdig = time_next(s.tdig);
                    n.meas_start = 1'b1;
                end
            end
            ST_OFFER: begin
                if (btn_press[2]) begin
                    n.mode = ST_HIBER_SHOW;
                end else if (v_edge) begin
                    n.mode = ST_MEASURE;
                end else if (tick && (s.sec_cnt == `OFFER_S - 3'h1)) begin
                    n.mode = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (v_edge) begin
                    n.mode = ST_MEASURE;
                end
            end
            ST_HIBER_SHOW, ST_HIBERNATE: begin
                if (v_edge) begin
                    n.mode = ST_ENTRY;
                    n.edit = 2'h0;
                    n.tdig = '0;
                end else if (s.mode == ST_HIBER_SHOW && tick
                             && (s.sec_cnt == `HIBER_SHOW_S - 3'h1)) begin
                    n.mode = ST_HIBERNATE;
                end
            end
            default: n.mode = ST_RESET;
        endcase
        if (n.mode != s.mode) begin
            n.sec_cnt = 3'h0;
        end
        n.clk_run = (n.mode != ST_SLEEP) && (n.mode != ST_HIBERNATE);
        n.periph_on = n.mode != ST_HIBERNATE;

        // Display
        n.disp = '0;
        n.colon = 1'b0;
        unique case (n.mode)
            ST_RESET: begin
                n.disp[7] = char_of(`VER_D8);
                n.disp[5] = char_of(`VER_D6);
                n.disp[4] = char_of(`VER_D5);
            end
            ST_ENTRY: begin
                n.colon = 1'b1;
                for (int i = 0; i < 4; i++) begin
                    if (i <= int'(n.edit)) begin
                        n.disp[5 - i] = char_of(n.tdig[5 - i]);
                    end
                end
            end
            ST_MEASURE: begin
                n.colon = 1'b1;
                for (int i = 0; i < 6; i++) begin
                    n.disp[i] = char_of(n.tdig[i]);
                end
            end
            ST_OFFER, ST_SLEEP: n.disp[7] = CH_S;
            ST_HIBER_SHOW: n.disp[7] = CH_H;
            default: n.disp = '0;
        endcase

        // Register bus, write side
        if (s.awready && awvalid) begin
            n.aw_got = 1'b1;
            n.aw_addr = awaddr;
        end
        if (s.wready && wvalid) begin
            n.w_got = 1'b1;
            n.wdata = wdata;
            n.wstrb = wstrb;
        end
        if (s.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        if (s.aw_got && s.w_got && !s.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = `RESP_SLVERR;
            if (s.aw_addr == `REG_PWM_REF) begin
                n.bresp = `RESP_OKAY;
                if (s.wstrb[0]) begin
                    n.pwm_ref[7:0] = s.wdata[7:0];
                end
                if (s.wstrb[1]) begin
                    n.pwm_ref[9:8] = s.wdata[9:8];
                end
            end
        end
        n.awready = !n.aw_got && !n.bvalid;
        n.wready = !n.w_got && !n.bvalid;

        // Register bus, read side
        if (s.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
        if (s.arready && arvalid) begin
            n.rvalid = 1'b1;
            n.rresp = `RESP_OKAY;
            n.rdata = 32'h0;
            unique case (araddr)
                `REG_STATUS: begin
                    n.rdata[`STATUS_MODE_LSB +: 3] = s.mode;
                    n.rdata[`STATUS_TRIAC_BIT] = s.triac_on;
                    n.rdata[`STATUS_EDIT_LSB +: 2] = s.edit;
                end
                `REG_TIME:    n.rdata[23:0] = s.tdig;
                `REG_FREQ:    n.rdata[7:0] = s.freq;
                `REG_PWM_REF: n.rdata[9:0] = s.pwm_ref;
                `REG_VERSION: n.rdata[11:0] = {`VER_D8, `VER_D6, `VER_D5};
                default:      n.rresp = `RESP_SLVERR;
            endcase
        end
        n.arready = !n.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.pwm_ref <= `PWM_REF_RESET;
            s.clk_run <= 1'b1;
            s.periph_on <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // =========================================================
    // Outputs
    assign combined_wake_interrupt = s.wake;
    assign load_triac_gate = s.gate;
    assign pwm_reference = s.pwm_out;
    assign meas_start = s.meas_start;
    assign cpu_clock_run = s.clk_run;
    assign periph_power_on = s.periph_on;
    assign display_char = s.disp;
    assign display_colon = s.colon;
    assign awready = s.awready;
    assign wready = s.wready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.arready;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;

    // =========================================================
    // Checks
    a_reset_mode_entry: assert property (@(posedge aclk) !aresetn |=> s.mode == ST_RESET)
        else $error("reset did not enter reset mode");
    a_reset_version_show: assert property (@(posedge aclk) disable iff (!aresetn)
        (s.mode == ST_RESET)[*3] |-> display_char[7] == char_of(`VER_D8))
        else $error("version not shown in reset mode");
    a_reset_load_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
        (s.mode == ST_RESET && btn_rel[0]) |=> $stable(s.triac_on))
        else $error("load switch acted in reset mode");
    a_load_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
        (s.mode != ST_RESET && btn_rel[0]) |=> s.triac_on != $past(s.triac_on))
        else $error("load switch did not toggle triac");
    a_edge_wake_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
        (v_edge || c_edge || rx_edge) |=> combined_wake_interrupt)
        else $error("sense edge gave no wake pulse");
    a_triac_gate_fire: assert property (@(posedge aclk) disable iff (!aresetn)
        load_triac_gate |-> $past(s.triac_on) && $past(v_edge))
        else $error("gate pulse without enable");
    a_sleep_wake: assert property (@(posedge aclk) disable iff (!aresetn)
        (s.mode == ST_SLEEP && v_edge) |=> s.mode == ST_MEASURE ##1 cpu_clock_run)
        else $error("sleep did not resume measurement");
    a_hiber_wake: assert property (@(posedge aclk) disable iff (!aresetn)
        (s.mode == ST_HIBERNATE && v_edge) |=> s.mode == ST_ENTRY && s.tdig == '0)
        else $error("hibernate did not return to entry");
    a_entry_to_measure: assert property (@(posedge aclk) disable iff (!aresetn)
        (s.mode == ST_ENTRY && s.edit == 2'h3 && btn_press[2]) |=> s.mode == ST_MEASURE)
        else $error("entry did not finish into measurement");
    a_time_day_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        (s.mode == ST_MEASURE && tick && !dropout
         && (s.tdig == 24'h235959 || s.tdig[5:4] == 8'h24)) |=> s.tdig == '0)
        else $error("time did not wrap at midnight");

endmodule

/* mains_model.sv */
`timescale 1ns/10ps

module mains_model #(
    parameter int HALF = 10
) (
    // Clock and mains presence
    input  wire logic aclk,
    input  wire logic mains_on,
    // Device outputs
    input  wire logic load_triac_gate,
    input  wire logic pwm_reference,
    // Comparator lines
    output logic      voltage_sense_line,
    output logic      current_sense_line
);
    int   cnt     = 0;
    logic load_on = 1'b0;
    logic level   = 1'b0;

    assign voltage_sense_line = level;
    // Half cycles only while mains is present
    always @(posedge aclk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (mains_on && cnt == HALF - 1)
            level <= ~level;
        if (load_triac_gate)
            load_on <= 1'b1;
        if (!mains_on)
            load_on <= 1'b0;
    end
    // Load current above the filtered reference
    assign current_sense_line = load_on & voltage_sense_line & ~pwm_reference;
endmodule

/* tb_top.sv */
`timescale 1ns/10ps
`include "meter_params.svh"

module tb_top;
    import meter_pkg::*;

    logic             aclk = 1'b0;
    logic             aresetn = 1'b0;
    logic [3:0]       btn = 4'h0;
    logic             mains_on = 1'b1;
    logic             serial_rx_line = 1'b0;
    logic             load_switch_button, increment_button, enter_button, decrement_button;
    logic             voltage_sense_line, current_sense_line, combined_wake_interrupt;
    logic             load_triac_gate, pwm_reference, meas_start, cpu_clock_run;
    logic             periph_power_on, display_colon;
    logic [7:0][4:0]  display_char;
    logic [7:0]       awaddr = 8'h00;
    logic [7:0]       araddr = 8'h00;
    logic [31:0]      wdata = 32'h0;
    logic [3:0]       wstrb = 4'hF;
    logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic             awready, wready, bvalid, arready, rvalid;
    logic [1:0]       bresp, rresp;
    logic [31:0]      rdata, d;
    logic [1:0]       r;
    logic             w;
    int               bad_count = 0;
    int               n_compared = 0;
    int               ms, gt;

    assign load_switch_button = btn[0];
    assign increment_button   = btn[1];
    assign enter_button       = btn[2];
    assign decrement_button   = btn[3];

    always #10 aclk = ~aclk;

    meter_mode_time_entry #(.DEBOUNCE_CYC(32'h4), .SCROLL_CYC(32'h14), .DROPOUT_CYC(32'h32),
        .SECOND_CYC(32'h64)) dut (.aclk, .aresetn, .load_switch_button, .increment_button,
        .enter_button, .decrement_button, .voltage_sense_line, .current_sense_line,
        .serial_rx_line, .combined_wake_interrupt, .load_triac_gate, .pwm_reference,
        .meas_start, .cpu_clock_run, .periph_power_on, .display_char, .display_colon,
        .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

    mains_model #(.HALF(10)) far_side (.aclk, .mains_on, .load_triac_gate, .pwm_reference,
        .voltage_sense_line, .current_sense_line);

    // =========================================
    // Compare and bus tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask

    task automatic chk_ch(input int i, input logic [4:0] e);
        chk("digit", {27'h0, e}, {27'h0, display_char[i]});
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] s);
        logic ta, tb;
        int   n;
        tb = 1'b0;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!tb && n < 50) begin
            @(negedge aclk);
            ta = arvalid & arready;
            tb = rvalid;
            q = rdata;
            s = rresp;
            n++;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tb) rready <= 1'b0;
        end
        @(posedge aclk);
        chk_bit("read answer", 1'b1, tb);
    endtask

    task automatic wc(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
        logic ta, tw, tb;
        int   n;
        tb = 1'b0;
        n = 0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!tb && n < 50) begin
            @(negedge aclk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            r = bresp;
            n++;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
        end
        chk("bresp", {30'h0, e}, {30'h0, r});
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] es);
        rd(a, d, r);
        chk("rdata", e, d);
        chk("rresp", {30'h0, es}, {30'h0, r});
    endtask

    task automatic waitmode(input mode_t m);
        int n;
        n = 0;
        d = 32'hFFFFFFFF;
        while (d[2:0] !== m && n < 200) begin
            rd(`REG_STATUS, d, r);
            n++;
        end
        chk("mode", {29'h0, m}, {29'h0, d[2:0]});
    endtask

    task automatic press(input int k, input int hold);
        btn[k] <= 1'b1;
        repeat (hold) @(posedge aclk);
        btn[k] <= 1'b0;
        repeat (12) @(posedge aclk);
    endtask

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        tally_and_finish;
    end

    // =========================================
    // Test sequence
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(negedge aclk);
        chk_ch(7, 5'h11);
        chk_ch(5, 5'h10);
        chk_ch(4, 5'h13);
        @(posedge aclk);
        press(0, 8);
        rc(`REG_STATUS, 32'h0, `RESP_OKAY);
        rc(`REG_PWM_REF, 32'h200, `RESP_OKAY);
        wc(`REG_PWM_REF, 32'h155, `RESP_OKAY);
        rc(`REG_PWM_REF, 32'h155, `RESP_OKAY);
        wc(`REG_STATUS, 32'h7, `RESP_SLVERR);
        rc(8'h3C, 32'h0, `RESP_SLVERR);
        rc(`REG_VERSION, 32'h103, `RESP_OKAY);
        $display("test reset done");
        waitmode(ST_ENTRY);
        @(negedge aclk);
        chk_ch(5, 5'h10);
        chk_bit("colon", 1'b1, display_colon);
        @(posedge aclk);
        for (int i = 0; i < 2; i++) press(1, 8);
        press(2, 8);
        for (int i = 0; i < 3; i++) press(1, 8);
        press(2, 8);
        press(1, 56);
        press(2, 8);
        press(3, 8);
        press(2, 8);
        rd(`REG_TIME, d, r);
        chk("time", 32'h2339, {16'h0, d[23:8]});
        waitmode(ST_MEASURE);
        @(negedge aclk);
        chk_ch(5, 5'h12);
        chk_ch(4, 5'h13);
        chk_ch(3, 5'h13);
        chk_ch(2, 5'h19);
        @(posedge aclk);
        $display("test entry done");
        press(0, 8);
        ms = 0;
        gt = 0;
        repeat (200) begin
            @(negedge aclk);
            ms += int'(meas_start === 1'b1);
            gt += int'(load_triac_gate === 1'b1);
        end
        @(posedge aclk);
        chk("ticks", 32'h2, ms);
        chk_bit("gates", 1'b1, gt >= 19);
        gt = 0;
        repeat (1024) begin
            @(negedge aclk);
            gt += int'(pwm_reference === 1'b1);
        end
        @(posedge aclk);
        chk("pwm duty", 32'h155, gt);
        rc(`REG_FREQ, 32'h5, `RESP_OKAY);
        rd(`REG_STATUS, d, r);
        chk_bit("triac", 1'b1, d[4]);
        $display("test measure done");
        mains_on <= 1'b0;
        waitmode(ST_OFFER);
        waitmode(ST_SLEEP);
        @(negedge aclk);
        chk_bit("cpu clock", 1'b0, cpu_clock_run);
        chk_ch(7, CH_S);
        @(posedge aclk);
        mains_on <= 1'b1;
        waitmode(ST_MEASURE);
        do @(negedge aclk); while (meas_start !== 1'b1);
        @(posedge aclk);
        mains_on <= 1'b0;
        waitmode(ST_OFFER);
        btn[2] <= 1'b1;
        waitmode(ST_HIBER_SHOW);
        @(negedge aclk);
        chk_ch(7, CH_H);
        @(posedge aclk);
        btn[2] <= 1'b0;
        waitmode(ST_HIBERNATE);
        @(negedge aclk);
        chk_bit("power", 1'b0, periph_power_on);
        chk_ch(7, CH_BLANK);
        @(posedge aclk);
        serial_rx_line <= 1'b1;
        w = 1'b0;
        repeat (3) begin
            @(negedge aclk);
            w = w | combined_wake_interrupt;
        end
        @(posedge aclk);
        chk_bit("wake", 1'b1, w);
        waitmode(ST_HIBERNATE);
        mains_on <= 1'b1;
        waitmode(ST_ENTRY);
        $display("test sleep done");
        for (int i = 0; i < 2; i++) press(1, 8);
        press(2, 8);
        press(3, 8);
        for (int i = 0; i < 3; i++) press(2, 8);
        waitmode(ST_MEASURE);
        do @(negedge aclk); while (meas_start !== 1'b1);
        @(posedge aclk);
        rd(`REG_TIME, d, r);
        chk("time", 32'h0, {16'h0, d[23:8]});
        $display("test wrap done");
        tally_and_finish;
    end
endmodule
